// [verilog/sfcf_regs.svh]
// Constants for the serial flash command framer
// Functional notes
// - Page opcodes take three address bytes: reserved, page, byte; some take none.
// - Extra don't-care bytes: four for D2h/E8h, one for D4h/D6h, else none.
// - After power-on or reset: clock mode 3, serial output high impedance.
// - Decoding starts only after chip select falls; host must drop it per instruction.
// - Each chip select fall in standby picks mode 3 or 0 from the idle clock level.
// - While power-on reset is active all commands are ignored.
// - After power-up the device enters standby, awaiting a selected instruction.
`ifndef SFCF_REGS_SVH
`define SFCF_REGS_SVH
`define SFCF_CLK_NS 100
`define SFCF_SELECT_DELAY_US 70
`define SFCF_WRITE_DELAY_MS 20
`define SFCF_SELECT_CYC ((`SFCF_SELECT_DELAY_US * 1000 + `SFCF_CLK_NS - 1) / `SFCF_CLK_NS)
`define SFCF_WRITE_CYC ((`SFCF_WRITE_DELAY_MS * 1000000) / `SFCF_CLK_NS)
`define SFCF_POR_CYC 16
`define SFCF_OP_MAIN_PAGE_READ 8'hD2
`define SFCF_OP_LEGACY_CONT_READ 8'hE8
`define SFCF_OP_BUF1_FAST_READ 8'hD4
`define SFCF_OP_BUF2_FAST_READ 8'hD6
`define SFCF_OP_BUF1_WRITE 8'h84
`define SFCF_OP_BUF2_WRITE 8'h87
`define SFCF_OP_BUF1_READ 8'hD1
`define SFCF_OP_BUF2_READ 8'hD3
`define SFCF_OP_ID_READ 8'h9F
`define SFCF_OP_DEEP_DOWN 8'hB9
`define SFCF_OP_RESUME 8'hAB
`define SFCF_OP_STATUS 8'hD7
`define SFCF_OP_PAGE_ERASE 8'h81
`define SFCF_OP_PROG_ERASE1 8'h83
`define SFCF_OP_PROG_ERASE2 8'h86
`define SFCF_OP_PROG_BUF1 8'h88
`define SFCF_OP_PROG_BUF2 8'h89
`define SFCF_OP_PROG_THRU1 8'h82
`define SFCF_OP_PROG_THRU2 8'h85
`endif

// [verilog/sfcf_pkg.sv]
// Types for the serial flash command framer
package sfcf_pkg;
    typedef enum logic [2:0] {
        SFCF_POR = 3'h0,
        SFCF_STANDBY = 3'h1,
        SFCF_OPCODE = 3'h2,
        SFCF_ADDR = 3'h3,
        SFCF_DUMMY = 3'h4,
        SFCF_DATA = 3'h5
    } sfcf_state_t;
endpackage

// [verilog/sfcf_frame.sv]
// Serial flash command framing and power-up state
`timescale 1ns/100ps
`include "sfcf_regs.svh"
module sfcf_frame
    import sfcf_pkg::*;
#(
    parameter int WRITE_CYC = `SFCF_WRITE_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe,
    output logic mode0,
    output logic standby,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [11:0] cmd_page,
    output logic [8:0] cmd_byte,
    output logic cmd_write_ok,
    output logic data_bit_valid,
    output logic data_bit
);
    localparam int CW = 25;

    // Pins sampled through two flops; stage one read only by stage two
    logic [1:0] cs_sync, sck_sync, si_sync;
    logic cs_prev, sck_prev;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cs_sync <= 2'h3;
            sck_sync <= 2'h3;
            si_sync <= 2'h0;
            cs_prev <= 1'b1;
            sck_prev <= 1'b1;
        end else begin
            cs_sync <= {cs_sync[0], cs_n};
            sck_sync <= {sck_sync[0], sck};
            si_sync <= {si_sync[0], si};
            cs_prev <= cs_sync[1];
            sck_prev <= sck_sync[1];
        end
    end
    logic cs_fall, cs_high, sck_rise;
    assign cs_fall = cs_prev & ~cs_sync[1];
    assign cs_high = cs_sync[1];
    assign sck_rise = ~sck_prev & sck_sync[1];

    function automatic logic [1:0] addr_bytes(input logic [7:0] op);
        unique case (op)
            `SFCF_OP_ID_READ, `SFCF_OP_DEEP_DOWN, `SFCF_OP_RESUME, `SFCF_OP_STATUS: addr_bytes = 2'h0;
            default: addr_bytes = 2'h3;
        endcase
    endfunction

    function automatic logic [2:0] dummy_bytes(input logic [7:0] op);
        unique case (op)
            `SFCF_OP_MAIN_PAGE_READ, `SFCF_OP_LEGACY_CONT_READ: dummy_bytes = 3'h4;
            `SFCF_OP_BUF1_FAST_READ, `SFCF_OP_BUF2_FAST_READ: dummy_bytes = 3'h1;
            default: dummy_bytes = 3'h0;
        endcase
    endfunction

    function automatic logic is_write(input logic [7:0] op);
        unique case (op)
            `SFCF_OP_PAGE_ERASE, `SFCF_OP_PROG_ERASE1, `SFCF_OP_PROG_ERASE2, `SFCF_OP_PROG_BUF1,
            `SFCF_OP_PROG_BUF2, `SFCF_OP_PROG_THRU1, `SFCF_OP_PROG_THRU2: is_write = 1'b1;
            default: is_write = 1'b0;
        endcase
    endfunction

    function automatic logic buf_only(input logic [7:0] op);
        unique case (op)
            `SFCF_OP_BUF1_WRITE, `SFCF_OP_BUF2_WRITE, `SFCF_OP_BUF1_READ, `SFCF_OP_BUF2_READ,
            `SFCF_OP_BUF1_FAST_READ, `SFCF_OP_BUF2_FAST_READ: buf_only = 1'b1;
            default: buf_only = 1'b0;
        endcase
    endfunction

    sfcf_state_t state, next_state;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [1:0] byte_cnt, next_byte_cnt;
    logic [2:0] dummy_cnt, next_dummy_cnt;
    logic [7:0] shreg, next_shreg;
    logic [15:0] addr, next_addr;
    logic [7:0] op_hold, next_op_hold;
    logic next_standby;
    logic [CW-1:0] up_cnt, next_up_cnt;
    logic next_mode0, next_cmd_valid, next_write_ok, next_dbv, next_db;
    logic [7:0] next_opcode;
    logic [11:0] next_page;
    logic [8:0] next_byte;
    logic [7:0] shifted;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_byte_cnt = byte_cnt;
        next_dummy_cnt = dummy_cnt;
        next_shreg = shreg;
        next_addr = addr;
        next_up_cnt = up_cnt;
        next_mode0 = mode0;
        next_cmd_valid = 1'b0;
        next_opcode = cmd_opcode;
        next_op_hold = op_hold;
        next_page = cmd_page;
        next_byte = cmd_byte;
        next_dbv = 1'b0;
        next_db = data_bit;
        next_write_ok = cmd_write_ok;
        shifted = {shreg[6:0], si_sync[1]};
        // Write lockout timer runs from reset release
        if (up_cnt != CW'(WRITE_CYC)) begin
            next_up_cnt = up_cnt + CW'(1);
        end
        unique case (state)
            SFCF_POR: begin
                // Inputs ignored until the internal reset window ends
                if (up_cnt >= CW'(`SFCF_POR_CYC)) begin
                    next_state = SFCF_STANDBY;
                end
            end
            SFCF_STANDBY: begin
                if (cs_fall) begin
                    next_mode0 = ~sck_sync[1];
                    next_state = SFCF_OPCODE;
                    next_bit_cnt = 5'h0;
                end
            end
            SFCF_OPCODE, SFCF_ADDR, SFCF_DUMMY, SFCF_DATA: begin
                if (cs_high) begin
                    next_state = SFCF_STANDBY;
                end else if (sck_rise) begin
                    next_shreg = shifted;
                    next_bit_cnt = bit_cnt + 5'h1;
                    if (state == SFCF_DATA) begin
                        next_dbv = 1'b1;
                        next_db = si_sync[1];
                    end else if (bit_cnt == 5'h7) begin
                        next_bit_cnt = 5'h0;
                        if (state == SFCF_OPCODE) begin
                            // Held aside so header fields move only with the cmd_valid pulse
                            next_op_hold = shifted;
                            next_byte_cnt = 2'h0;
                            next_dummy_cnt = dummy_bytes(shifted);
                            next_state = (addr_bytes(shifted) == 2'h0) ? SFCF_DATA : SFCF_ADDR;
                            if (addr_bytes(shifted) == 2'h0) begin
                                // No address bytes, so the header is already complete
                                next_opcode = shifted;
                                next_cmd_valid = 1'b1;
                            end
                        end else if (state == SFCF_ADDR) begin
                            next_addr = {addr[7:0], shifted};
                            next_byte_cnt = byte_cnt + 2'h1;
                            if (byte_cnt == 2'h2) begin
                                // First byte: three reserved bits, then page bits 11..7
                                // Second byte: page bits 6..0, then byte bit 8
                                next_page = buf_only(op_hold) ? 12'h0 : addr[12:1];
                                next_byte = {addr[0], shifted};
                                next_opcode = op_hold;
                                next_write_ok = up_cnt == CW'(WRITE_CYC);
                                next_cmd_valid = 1'b1;
                                next_state = (dummy_cnt == 3'h0) ? SFCF_DATA : SFCF_DUMMY;
                            end
                        end else begin
                            next_dummy_cnt = dummy_cnt - 3'h1;
                            if (dummy_cnt == 3'h1) begin
                                next_state = SFCF_DATA;
                            end
                        end
                    end
                end
            end
            default: next_state = SFCF_POR;
        endcase
        // Flag follows the state about to be entered
        next_standby = (next_state == SFCF_STANDBY);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= SFCF_POR;
            bit_cnt <= 5'h0;
            byte_cnt <= 2'h0;
            dummy_cnt <= 3'h0;
            shreg <= 8'h0;
            addr <= 16'h0;
            op_hold <= 8'h0;
            up_cnt <= '0;
            mode0 <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_opcode <= 8'h0;
            cmd_page <= 12'h0;
            cmd_byte <= 9'h0;
            cmd_write_ok <= 1'b0;
            data_bit_valid <= 1'b0;
            data_bit <= 1'b0;
            standby <= 1'b0;
            so <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            byte_cnt <= next_byte_cnt;
            dummy_cnt <= next_dummy_cnt;
            shreg <= next_shreg;
            addr <= next_addr;
            op_hold <= next_op_hold;
            up_cnt <= next_up_cnt;
            mode0 <= next_mode0;
            cmd_valid <= next_cmd_valid;
            cmd_opcode <= next_opcode;
            cmd_page <= next_page;
            cmd_byte <= next_byte;
            cmd_write_ok <= next_write_ok;
            data_bit_valid <= next_dbv;
            data_bit <= next_db;
            standby <= next_standby;
            // No read data path here, so the output stays released
            so <= 1'b0;
            so_oe <= 1'b0;
        end
    end
endmodule

// [tb/sfcf_frame_sva.sv]
// Port assertions for the command framer
`timescale 1ns/100ps
module sfcf_frame_sva #(
    parameter int WRITE_CYC = 64
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic so,
    input wire logic so_oe,
    input wire logic mode0,
    input wire logic standby,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic cmd_write_ok,
    input wire logic data_bit_valid
);
    int age;
    int next_age;
    // Saturates so a long run cannot wrap
    always_comb next_age = sys_rst ? 0 : (age < WRITE_CYC) ? age + 1 : age;
    always_ff @(posedge ref_clk) age <= next_age;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence take_s;
        standby && $fell(cs_n);
    endsequence
    so_hiz_a: assert property (!so_oe && !so) else $error("serial output driven");
    reset_idle_a: assert property (disable iff (1'b0) sys_rst |=> !mode0 && !standby && !cmd_valid)
        else $error("reset state wrong");
    por_quiet_a: assert property ($fell(sys_rst) |-> (!standby && !cmd_valid) [*8] ##1 !standby [*8])
        else $error("active during power-on window");
    standby_up_a: assert property ($fell(sys_rst) |-> ##[1:40] standby) else $error("no standby");
    select_take_a: assert property (take_s |-> ##[2:6] !standby) else $error("select not taken");
    mode_pick_a: assert property (take_s |-> ##6 mode0 == !$past(sck, 6)) else $error("clock mode wrong");
    valid_pulse_a: assert property (cmd_valid |=> !cmd_valid) else $error("header pulse too long");
    bit_pulse_a: assert property (data_bit_valid |=> !data_bit_valid) else $error("bit pulse too long");
    hdr_hold_a: assert property ($changed(cmd_opcode) |-> cmd_valid) else $error("opcode moved");
    write_lock_a: assert property (age < WRITE_CYC |-> !cmd_write_ok) else $error("write too early");
endmodule

// [tb/sfcf_host.sv]
// Host model driving the framer pins
`timescale 1ns/100ps
module sfcf_host (
    input wire logic ref_clk,
    output logic cs_n,
    output logic sck,
    output logic si
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        si = 1'b0;
    end
    // Clock parks at its idle level outside frames
    task automatic xfer(input logic [71:0] bits, input logic m0);
        sck <= !m0;
        repeat (2) @(posedge ref_clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (int i = 71; i >= 0; i--) begin
            sck <= 1'b0;
            si <= bits[i];
            repeat (4) @(posedge ref_clk);
            sck <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
        sck <= !m0;
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b1;
        si <= !si;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// [tb/tb_serial_flash_cmd_frame_powerup.sv]
// Self-checking bench for the command framer
`timescale 1ns/100ps
`include "sfcf_regs.svh"
module tb_serial_flash_cmd_frame_powerup;
    localparam int WCYC = 1200;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cs_n, sck, si, so, so_oe, mode0, standby, cmd_valid, cmd_write_ok, data_bit_valid, data_bit;
    logic [7:0] cmd_opcode;
    logic [11:0] cmd_page;
    logic [8:0] cmd_byte;
    logic [30:0] eq[$], mq[$], e, m;
    logic dq[$];
    logic [31:0] seed = 32'h1E2C86D5;
    logic [7:0] ops[19] = '{8'hD2, 8'hE8, 8'hD4, 8'hD6, 8'hD1, 8'hD3, 8'h9F, 8'hB9, 8'hAB, 8'hD7,
        8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89};
    int failures = 0;
    int checks = 0;
    int since = 0;
    sfcf_frame #(.WRITE_CYC(WCYC)) sfcf_frame_inst (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .so(so),
        .so_oe(so_oe),
        .mode0(mode0),
        .standby(standby),
        .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode),
        .cmd_page(cmd_page),
        .cmd_byte(cmd_byte),
        .cmd_write_ok(cmd_write_ok),
        .data_bit_valid(data_bit_valid),
        .data_bit(data_bit)
    );
    sfcf_host sfcf_host_inst (
        .ref_clk(ref_clk),
        .cs_n(cs_n),
        .sck(sck),
        .si(si)
    );
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string name, input logic [30:0] seen, input logic [30:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic frame(input logic [7:0] op, input logic m0, input logic take);
        logic [71:0] b;
        int hb;
        int nd;
        b = {rnd(), rnd(), seed[7:0]};
        b[71:64] = op;
        hb = (op inside {8'h9F, 8'hB9, 8'hAB, 8'hD7}) ? 8 : 32;
        nd = (op inside {8'hD2, 8'hE8}) ? 32 : (op inside {8'hD4, 8'hD6}) ? 8 : 0;
        if (take) begin
            eq.push_back({1'b0, m0, op, (op inside {8'h84, 8'h87, 8'hD1, 8'hD3, 8'hD4, 8'hD6}) ? 12'h000 : b[60:49],
                b[48:40]});
            mq.push_back(hb == 8 ? 31'h3FE0_0000 : 31'h7FFF_FFFF);
            for (int i = 71 - hb - nd; i >= 0; i--) dq.push_back(b[i]);
            for (int i = 0; i < 100 && standby !== 1'b1; i++) @(posedge ref_clk);
        end
        sfcf_host_inst.xfer(b, m0);
    endtask
    always @(negedge ref_clk) begin
        since = sys_rst ? 0 : since + 1;
        if (cmd_valid === 1'b1) begin
            if (eq.size() == 0) check("extra header", 31'h1, 31'h0);
            else begin
                e = eq.pop_front();
                m = mq.pop_front();
                // Header edge sees the lockout count two cycles behind this negedge count
                e[30] = since > WCYC + 1;
                check("header", {cmd_write_ok, mode0, cmd_opcode, cmd_page, cmd_byte} & m, e & m);
            end
        end
        if (data_bit_valid === 1'b1) check("data bit", 31'(data_bit), 31'(dq.size() ? dq.pop_front() : !data_bit));
    end
    initial forever #50 ref_clk = ~ref_clk;
    initial begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (`SFCF_SELECT_CYC) @(posedge ref_clk);
        foreach (ops[i]) frame(ops[i], i[0], 1'b1);
        frame(8'h85, 1'b1, 1'b1);
        sys_rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        check("reset state", 31'({mode0, standby, so_oe}), 31'h0);
        @(posedge ref_clk);
        // Selected inside the power-on window, so it must be ignored
        frame(8'h9F, 1'b0, 1'b0);
        frame(8'hD4, 1'b1, 1'b1);
        repeat (20) @(posedge ref_clk);
        check("left over", 31'(eq.size() + dq.size()), 31'h0);
        test_done();
    end
endmodule
bind sfcf_frame sfcf_frame_sva #(.WRITE_CYC(WRITE_CYC)) sfcf_frame_sva_inst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cs_n(cs_n),
    .sck(sck),
    .so(so),
    .so_oe(so_oe),
    .mode0(mode0),
    .standby(standby),
    .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode),
    .cmd_write_ok(cmd_write_ok),
    .data_bit_valid(data_bit_valid)
);
